// ==== design/sfg_regs.svh ====
// Constants for the system flag generator: offsets, bit positions, reset values and timing.
// Function
// - Eight square-wave flags, 20 ms to 60 s periods, each inverting every half period.
// - Square-wave flags change only at scan end, so edges may be late.
// - Square-wave flags start low when initialisation starts, and at scan program start unless a hot restart restores them.
// - First-scan flag high only in first scan; its complement low only then.
// - Scan-alternation flag inverts every scan and is high in the first scan.
// - Setting initialisation-complete ends initialisation and starts the scan program.
// - Date counts days from Jan. 1, 1984; time of day counts from 00:00:00.
// - Weekday index runs Monday 0 up to Sunday 6.
// - Marked flags reset when initialisation starts; afterwards restart mode decides.
// - Cold or warm restart reinitialises marked flags when the scan program begins.
// - Hot restart restores marked flags saved at the last stop when scan begins.
// - Function error flag is rewritten by every function operation, latest result only.
// - Block error latch sets on any block error; software may also write it.
// - Sixteen-bit fatal error word gathers stop errors; bit 7 unused.
// - Bit 1 flags module type mismatch or a module in a forbidden slot.
// - Bit 2 flags module configuration change during run.
// - Bit 3 flags an open fuse in any fused slot.
// - Bit 4 flags an I/O module read or write failure.
// - Bit 5 flags special or communication module init or interface failure.
// - Bit 6 flags external fatal fault; user program writes its code array.
// - Bit 8 flags a scan exceeding the watchdog limit.
// - Bit 9 flags unreadable instruction; bit 11 flags corrupt memory or program.
// - Cold, warm or hot restart mode is a stored parameter applied at every restart.
`ifndef SFG_REGS_SVH
`define SFG_REGS_SVH

// ==========================================================================
// Register offsets (word index on the plain register port)
`define SFG_OFS_CTRL 4'h0
`define SFG_OFS_STATUS 4'h1
`define SFG_OFS_FATAL 4'h2
`define SFG_OFS_DATE 4'h3
`define SFG_OFS_TOD 4'h4
`define SFG_OFS_FLAGS 4'h5
`define SFG_OFS_CODE 4'h6

// ==========================================================================
// Control register fields
`define SFG_CTRL_MODE_LO 0
`define SFG_CTRL_BLKERR 2
`define SFG_CTRL_INIT_DONE 3
`define SFG_CTRL_START 4
`define SFG_CTRL_STOP 5

// ==========================================================================
// Fatal error word bit positions
`define SFG_FB_TYPE 1
`define SFG_FB_SWAP 2
`define SFG_FB_FUSE 3
`define SFG_FB_IO 4
`define SFG_FB_SP 5
`define SFG_FB_EXT 6
`define SFG_FB_WD 8
`define SFG_FB_CODE 9
`define SFG_FB_PROG 11

// ==========================================================================
// Timing and calendar
`define SFG_CLK_HZ 125000000
`define SFG_TICK_MS 10
`define SFG_TICK_CYC ((`SFG_CLK_HZ / 1000) * `SFG_TICK_MS)
`define SFG_TICKS_PER_SEC 100
`define SFG_SEC_PER_DAY 17'h15180
`define SFG_DATE_RESET 16'h0000
`define SFG_WEEKDAY_RESET 3'h6
`define SFG_WEEKDAY_LAST 3'h6

`endif

// ==== design/sfg_pkg.sv ====
// Types shared by the system flag generator.
package sfg_pkg;
   typedef enum logic [1:0] {
      SFG_COLD = 2'h0,
      SFG_WARM = 2'h1,
      SFG_HOT = 2'h2
   } sfg_restart_t;

   typedef enum logic [2:0] {
      SFG_ST_STOP = 3'h1,
      SFG_ST_INIT = 3'h2,
      SFG_ST_SCAN = 3'h4
   } sfg_state_t;

   // Marked flags that restart handling saves and restores.
   typedef struct packed {
      logic [7:0] square;
      logic first_high;
      logic first_low;
      logic alternation;
   } sfg_marked_t;

   // Stop-error sources sampled from the runtime.
   typedef struct packed {
      logic module_type_mismatch;
      logic module_swap_during_run;
      logic slot_fuse_open;
      logic io_access_fault;
      logic special_module_interface_fault;
      logic external_fatal_fault;
      logic scan_overrun_fault;
      logic bad_instruction_fault;
      logic program_corrupt_fault;
   } sfg_fault_t;
endpackage : sfg_pkg

// ==== design/sfg_flag_gen.sv ====
// System flag generator: scan-synchronised flags, calendar and fatal error word.
`timescale 1ns/1ps
`include "sfg_regs.svh"

module sfg_flag_gen #(
   parameter int TICK_CYC = `SFG_TICK_CYC,
   parameter int WDOG_LIMIT = 1000000
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Runtime scan events
   input wire logic scan_end,
   input wire logic fn_exec,
   input wire logic fn_err,
   input wire logic blk_err,
   input wire logic fetch_bad,
   input wire sfg_pkg::sfg_fault_t faults,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Flags for user programs
   output sfg_pkg::sfg_marked_t marked,
   output logic always_one,
   output logic always_zero,
   output logic fn_error_flag,
   output logic block_error_latch,
   output logic [15:0] fatal_system_error_word,
   output logic [15:0] date_days,
   output logic [16:0] time_of_day,
   output logic [2:0] weekday_index,
   output logic scan_running
);

   // ==========================================================================
   // Register decode
   wire wr_ctrl = reg_wr && (reg_addr == `SFG_OFS_CTRL);
   wire wr_code = reg_wr && (reg_addr == `SFG_OFS_CODE);
   wire start_req = wr_ctrl && reg_wdata[`SFG_CTRL_START];
   wire stop_req = wr_ctrl && reg_wdata[`SFG_CTRL_STOP];
   wire done_req = wr_ctrl && reg_wdata[`SFG_CTRL_INIT_DONE];

   sfg_pkg::sfg_state_t state_ff, nxt_state;
   sfg_pkg::sfg_restart_t mode_ff;
   sfg_pkg::sfg_marked_t saved_ff;
   logic [15:0] ext_code_ff;
   logic [31:0] tick_cnt_ff;
   logic [31:0] wd_cnt_ff;
   logic [6:0] sub_ff;
   logic [31:0] ms_ff;
   logic [6:0] ms_div_ff;

   // Scan program start: restart handling applies here.
   wire enter_init = (state_ff == sfg_pkg::SFG_ST_STOP) && start_req;
   wire enter_scan = (state_ff == sfg_pkg::SFG_ST_INIT) && done_req;
   wire running = (state_ff != sfg_pkg::SFG_ST_STOP);

   // Run-state sequencer.
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         sfg_pkg::SFG_ST_STOP: if (start_req) nxt_state = sfg_pkg::SFG_ST_INIT;
         sfg_pkg::SFG_ST_INIT: begin
            if (stop_req) nxt_state = sfg_pkg::SFG_ST_STOP;
            else if (done_req) nxt_state = sfg_pkg::SFG_ST_SCAN;
         end
         sfg_pkg::SFG_ST_SCAN: if (stop_req) nxt_state = sfg_pkg::SFG_ST_STOP;
         default: nxt_state = sfg_pkg::SFG_ST_STOP;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) state_ff <= sfg_pkg::SFG_ST_STOP;
      else state_ff <= nxt_state;
   end

   // Restart mode is a stored parameter; it is used at every start.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) mode_ff <= sfg_pkg::SFG_COLD;
      else if (wr_ctrl && (state_ff == sfg_pkg::SFG_ST_STOP)) begin
         mode_ff <= sfg_pkg::sfg_restart_t'(reg_wdata[`SFG_CTRL_MODE_LO +: 2]);
      end
   end

   // ==========================================================================
   // Time base: one tick every 10 ms, half-period counters per square flag.
   wire tick = (tick_cnt_ff == 32'(TICK_CYC - 1));
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) tick_cnt_ff <= 32'h0;
      else tick_cnt_ff <= tick ? 32'h0 : tick_cnt_ff + 32'h1;
   end

   localparam int NSQ = 8;
   localparam int HALF_TICKS [NSQ] = '{1, 5, 10, 50, 100, 500, 1000, 3000};
   logic [NSQ-1:0] half_due;
   logic [NSQ-1:0] pend_ff;
   wire scan_start = enter_init || enter_scan;

   // Half periods are counted in ticks; the flag itself waits for scan end.
   // A half period due in the scan-end cycle is used by that scan at once, so the clear must win there.
   genvar g;
   generate
      for (g = 0; g < NSQ; g++) begin : g_sq
         logic [11:0] cnt_ff;
         assign half_due[g] = tick && (cnt_ff == 12'(HALF_TICKS[g] - 1));
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) cnt_ff <= 12'h0;
            else if (scan_start) cnt_ff <= 12'h0;
            else if (half_due[g]) cnt_ff <= 12'h0;
            else if (tick) cnt_ff <= cnt_ff + 12'h1;
         end
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) pend_ff[g] <= 1'b0;
            else if (scan_start) pend_ff[g] <= 1'b0;
            else if (scan_end && running) pend_ff[g] <= 1'b0;
            else if (half_due[g]) pend_ff[g] <= 1'b1;
         end
      end
   endgenerate

   // ==========================================================================
   // Marked flags: initial values, scan updates and hot-restart restore.
   localparam sfg_pkg::sfg_marked_t MARKED_INIT = '{square: 8'h00, first_high: 1'b1,
                                                   first_low: 1'b0, alternation: 1'b1};
   sfg_pkg::sfg_marked_t nxt_marked;
   wire hot = (mode_ff == sfg_pkg::SFG_HOT);
   wire scan_done = scan_end && running;

   always_comb begin
      nxt_marked = marked;
      if (enter_init) begin
         nxt_marked = MARKED_INIT;
      end else if (enter_scan) begin
         nxt_marked = hot ? saved_ff : MARKED_INIT;
      end else if (scan_done) begin
         nxt_marked.square = marked.square ^ (pend_ff | half_due);
         nxt_marked.first_high = 1'b0;
         nxt_marked.first_low = 1'b1;
         nxt_marked.alternation = ~marked.alternation;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) marked <= '{square: 8'h00, first_high: 1'b1, first_low: 1'b0, alternation: 1'b1};
      else marked <= nxt_marked;
   end

   // Snapshot at stop so a hot restart can continue from it.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) saved_ff <= '{square: 8'h00, first_high: 1'b1, first_low: 1'b0, alternation: 1'b1};
      else if (stop_req && running) saved_ff <= marked;
   end

   // Constant flags.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         always_one <= 1'b1;
         always_zero <= 1'b0;
      end else begin
         always_one <= 1'b1;
         always_zero <= 1'b0;
      end
   end

   // ==========================================================================
   // Operation error flags.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) fn_error_flag <= 1'b0;
      else if (fn_exec) fn_error_flag <= fn_err;
   end

   // Hardware set wins over a software write of zero in the same cycle.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) block_error_latch <= 1'b0;
      else if (blk_err) block_error_latch <= 1'b1;
      else if (wr_ctrl) block_error_latch <= reg_wdata[`SFG_CTRL_BLKERR];
   end

   // ==========================================================================
   // Scan watchdog counts cycles since the last scan end.
   wire wd_trip = running && (wd_cnt_ff >= 32'(WDOG_LIMIT));
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) wd_cnt_ff <= 32'h0;
      else if (!running || scan_end) wd_cnt_ff <= 32'h0;
      else if (!wd_trip) wd_cnt_ff <= wd_cnt_ff + 32'h1;
   end

   // Fatal word bits stick until the next start; bit 7 and unlisted bits stay zero.
   logic [15:0] fault_vec;
   always_comb begin
      fault_vec = 16'h0000;
      fault_vec[`SFG_FB_TYPE] = faults.module_type_mismatch;
      fault_vec[`SFG_FB_SWAP] = faults.module_swap_during_run && running;
      fault_vec[`SFG_FB_FUSE] = faults.slot_fuse_open;
      fault_vec[`SFG_FB_IO] = faults.io_access_fault;
      fault_vec[`SFG_FB_SP] = faults.special_module_interface_fault;
      fault_vec[`SFG_FB_EXT] = faults.external_fatal_fault;
      fault_vec[`SFG_FB_WD] = faults.scan_overrun_fault || wd_trip;
      fault_vec[`SFG_FB_CODE] = faults.bad_instruction_fault || fetch_bad;
      fault_vec[`SFG_FB_PROG] = faults.program_corrupt_fault;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) fatal_system_error_word <= 16'h0000;
      else if (enter_init) fatal_system_error_word <= fault_vec;
      else fatal_system_error_word <= fatal_system_error_word | fault_vec;
   end

   // External fault code written by the user program.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) ext_code_ff <= 16'h0000;
      else if (wr_code) ext_code_ff <= reg_wdata[15:0];
   end

   // ==========================================================================
   // Calendar: seconds of day, days since reference, weekday.
   wire sec_tick = tick && (sub_ff == 7'(`SFG_TICKS_PER_SEC - 1));
   wire day_wrap = sec_tick && (time_of_day == (`SFG_SEC_PER_DAY - 17'h1));
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) sub_ff <= 7'h0;
      else if (sec_tick) sub_ff <= 7'h0;
      else if (tick) sub_ff <= sub_ff + 7'h1;
   end

   // The reference day was a Sunday, hence the weekday reset value.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         time_of_day <= 17'h0;
         date_days <= `SFG_DATE_RESET;
         weekday_index <= `SFG_WEEKDAY_RESET;
      end else if (day_wrap) begin
         time_of_day <= 17'h0;
         date_days <= date_days + 16'h1;
         weekday_index <= (weekday_index == `SFG_WEEKDAY_LAST) ? 3'h0 : weekday_index + 3'h1;
      end else if (sec_tick) begin
         time_of_day <= time_of_day + 17'h1;
      end
   end

   // ==========================================================================
   // Read path: data valid in the cycle after the read strobe.
   wire [31:0] rd_mux =
      (reg_addr == `SFG_OFS_CTRL) ? {28'h0, block_error_latch, 1'b0, 2'(mode_ff)} :
      (reg_addr == `SFG_OFS_STATUS) ? {29'h0, 3'(state_ff)} :
      (reg_addr == `SFG_OFS_FATAL) ? {16'h0, fatal_system_error_word} :
      (reg_addr == `SFG_OFS_DATE) ? {13'h0, weekday_index, date_days} :
      (reg_addr == `SFG_OFS_TOD) ? {15'h0, time_of_day} :
      (reg_addr == `SFG_OFS_FLAGS) ? {20'h0, fn_error_flag, 11'(marked)} :
      (reg_addr == `SFG_OFS_CODE) ? {16'h0, ext_code_ff} : 32'h0;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) reg_rdata <= 32'h0;
      else reg_rdata <= reg_rd ? rd_mux : 32'h0;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) scan_running <= 1'b0;
      else scan_running <= (nxt_state == sfg_pkg::SFG_ST_SCAN);
   end

   // ==========================================================================
   // Checks.
   first_scan_a: assert property (@(posedge clk) disable iff (!arst_n)
      (marked.first_high && scan_done && !scan_start) |=> !marked.first_high && marked.first_low)
      else $error("First-scan flag did not drop after scan.");
   toggle_scan_a: assert property (@(posedge clk) disable iff (!arst_n)
      (scan_done && !scan_start) |=> marked.alternation != $past(marked.alternation))
      else $error("Scan toggle flag did not invert.");
   square_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
      (!scan_done && !scan_start) |=> $stable(marked.square))
      else $error("Square flag moved outside scan end.");
   init_low_a: assert property (@(posedge clk) disable iff (!arst_n)
      enter_init |=> marked.square == 8'h00)
      else $error("Square flags not low at start.");
   cold_init_a: assert property (@(posedge clk) disable iff (!arst_n)
      (enter_scan && !hot) |=> marked.first_high && marked.alternation && marked.square == 8'h00)
      else $error("Cold restart did not reinitialise.");
   hot_restore_a: assert property (@(posedge clk) disable iff (!arst_n)
      (enter_scan && hot) |=> marked == $past(saved_ff))
      else $error("Hot restart did not restore.");
   fn_error_a: assert property (@(posedge clk) disable iff (!arst_n)
      fn_exec |=> fn_error_flag == $past(fn_err))
      else $error("Function error flag not rewritten.");
   blk_latch_a: assert property (@(posedge clk) disable iff (!arst_n)
      blk_err |=> block_error_latch)
      else $error("Block error did not latch.");
   bit_seven_a: assert property (@(posedge clk) disable iff (!arst_n)
      !fatal_system_error_word[7])
      else $error("Unused fatal bit set.");
   watchdog_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
      (wd_trip && !enter_init) |=> fatal_system_error_word[`SFG_FB_WD])
      else $error("Watchdog overrun not flagged.");
   const_flags_a: assert property (@(posedge clk) disable iff (!arst_n)
      always_one && !always_zero)
      else $error("Constant flags wrong.");

   // The first-scan pair must stay complementary, even after a hot restore.
   first_pair_a: assert property (@(posedge clk) disable iff (!arst_n)
      marked.first_low == !marked.first_high)
      else $error("First-scan flags not complementary.");
   init_done_a: assert property (@(posedge clk) disable iff (!arst_n)
      (enter_scan && !stop_req) |=> scan_running)
      else $error("Scan program did not start.");

   // Each stop-error source reaches its bit one cycle later, and bits only clear at a start.
   type_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
      faults.module_type_mismatch |=> fatal_system_error_word[`SFG_FB_TYPE])
      else $error("Module type error not flagged.");
   swap_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
      (faults.module_swap_during_run && running) |=> fatal_system_error_word[`SFG_FB_SWAP])
      else $error("Module swap error not flagged.");
   fuse_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
      faults.slot_fuse_open |=> fatal_system_error_word[`SFG_FB_FUSE])
      else $error("Fuse error not flagged.");
   code_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
      fetch_bad |=> fatal_system_error_word[`SFG_FB_CODE])
      else $error("Bad fetch not flagged.");
   prog_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
      faults.program_corrupt_fault |=> fatal_system_error_word[`SFG_FB_PROG])
      else $error("Program error not flagged.");
   fatal_sticky_a: assert property (@(posedge clk) disable iff (!arst_n)
      !enter_init |=> (fatal_system_error_word & $past(fatal_system_error_word)) == $past(fatal_system_error_word))
      else $error("Fatal bit cleared without a start.");

   // Calendar values stay in range and roll over together.
   tod_range_a: assert property (@(posedge clk) disable iff (!arst_n)
      time_of_day < `SFG_SEC_PER_DAY)
      else $error("Time of day out of range.");
   weekday_range_a: assert property (@(posedge clk) disable iff (!arst_n)
      weekday_index <= `SFG_WEEKDAY_LAST)
      else $error("Weekday index out of range.");
   day_step_a: assert property (@(posedge clk) disable iff (!arst_n)
      day_wrap |=> time_of_day == 17'h0 && date_days == $past(date_days) + 16'h1)
      else $error("Day rollover wrong.");
   weekday_wrap_a: assert property (@(posedge clk) disable iff (!arst_n)
      (day_wrap && weekday_index == `SFG_WEEKDAY_LAST) |=> weekday_index == 3'h0)
      else $error("Weekday did not wrap to zero.");

   // Main scenarios worth seeing at least once.
   start_scan_c: cover property (@(posedge clk) disable iff (!arst_n) enter_scan && hot);
   cold_start_c: cover property (@(posedge clk) disable iff (!arst_n) enter_scan && !hot);
   square_flip_c: cover property (@(posedge clk) disable iff (!arst_n) scan_done && (pend_ff != 8'h00));
   watchdog_c: cover property (@(posedge clk) disable iff (!arst_n) wd_trip);
   day_wrap_c: cover property (@(posedge clk) disable iff (!arst_n) day_wrap);

endmodule : sfg_flag_gen

// ==== tb/tb.sv ====
// Self-checking bench for the system flag generator, driven through its register port and its runtime event inputs.
`timescale 1ns/1ps

module tb;
   // ==========================================================================
   // Shortened timing: one 10 ms tick is four clocks, the scan watchdog fifty.
   localparam int TICK = 4;
   localparam int WDOG = 50;
   localparam int SEC = 100 * TICK;
   localparam logic [10:0] MARK_INIT = 11'h005;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic scan_end = 1'b0;
   logic fn_exec = 1'b0;
   logic fn_err = 1'b0;
   logic blk_err = 1'b0;
   logic fetch_bad = 1'b0;
   sfg_pkg::sfg_fault_t faults = 9'h000;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   sfg_pkg::sfg_marked_t marked;
   logic always_one;
   logic always_zero;
   logic fn_error_flag;
   logic block_error_latch;
   logic [15:0] fatal_system_error_word;
   logic [15:0] date_days;
   logic [16:0] time_of_day;
   logic [2:0] weekday_index;
   logic scan_running;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;
   int n0 = 0;
   int n1 = 0;
   int c_start;
   int el;
   int fb[9] = '{1, 2, 3, 4, 5, 6, 8, 9, 11};
   logic count_on = 1'b0;
   logic [1:0] sq_prev = 2'h0;
   logic [31:0] rd;
   logic [16:0] t0;
   logic [10:0] saved;
   logic [15:0] exp_fatal = 16'h0000;

   sfg_flag_gen #(.TICK_CYC(TICK), .WDOG_LIMIT(WDOG)) dut (
      .clk(clk), .arst_n(arst_n), .scan_end(scan_end), .fn_exec(fn_exec), .fn_err(fn_err),
      .blk_err(blk_err), .fetch_bad(fetch_bad), .faults(faults), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .marked(marked), .always_one(always_one), .always_zero(always_zero),
      .fn_error_flag(fn_error_flag), .block_error_latch(block_error_latch),
      .fatal_system_error_word(fatal_system_error_word), .date_days(date_days),
      .time_of_day(time_of_day), .weekday_index(weekday_index), .scan_running(scan_running)
   );

   // Free-running clock and a cycle count used to judge square-wave rates.
   always #4 clk = ~clk;

   // Toggle counter; sampling before the edge's updates keeps it race free.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      sq_prev <= marked.square[1:0];
      if (count_on && marked.square[0] !== sq_prev[0]) n0 <= n0 + 1;
      if (count_on && marked.square[1] !== sq_prev[1]) n1 <= n1 + 1;
   end

   // ==========================================================================
   // Access tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t ns: got %0h expected %0h", $time, got, exp);
         err_total++;
      end
   endtask : chk

   // The extra edge lets the write's effect land before anything is sampled.
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
      #1;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read

   task automatic pulse_scan();
      @(posedge clk);
      scan_end <= 1'b1;
      @(posedge clk);
      scan_end <= 1'b0;
      @(posedge clk);
      #1;
   endtask : pulse_scan

   task automatic fn_op(input logic e);
      @(posedge clk);
      fn_exec <= 1'b1;
      fn_err <= e;
      @(posedge clk);
      fn_exec <= 1'b0;
      fn_err <= 1'b0;
      @(posedge clk);
      #1;
   endtask : fn_op

   // Stop, load a restart mode, then start again with that mode; initialisation is left open.
   task automatic restart(input logic [1:0] m);
      reg_write(4'h0, 32'h0000_0020);
      reg_write(4'h0, {30'h0, m});
      reg_write(4'h0, {27'h0, 1'b1, 2'h0, m});
   endtask : restart

   task automatic wrap_up();
      if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   // Watchdog sized well above the fifteen hundred or so cycles the sequence needs.
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      wrap_up();
   end

   // ==========================================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      chk(always_one, 32'h1);
      chk(always_zero, 32'h0);
      chk(marked, MARK_INIT);
      chk({weekday_index, date_days}, 32'h0006_0000);
      reg_read(4'h3, rd);
      chk(rd, 32'h0006_0000);
      reg_read(4'h1, rd);
      chk(rd, 32'h1);
      reg_write(4'h9, 32'hFFFF_FFFF);
      reg_read(4'h9, rd);
      chk(rd, 32'h0);
      // Time of day advances by exactly one second per second of ticks.
      t0 = time_of_day;
      for (int i = 0; i < SEC + 50 && time_of_day === t0; i++) begin
         @(posedge clk);
         #1;
      end
      t0 = time_of_day;
      repeat (SEC / 2) @(posedge clk);
      #1;
      chk(time_of_day, t0);
      repeat (SEC) @(posedge clk);
      #1;
      chk(time_of_day, t0 + 17'h1);
      reg_read(4'h4, rd);
      chk(rd, t0 + 17'h1);
      // Start, initialisation handshake, first scan.
      reg_write(4'h0, 32'h0000_0010);
      reg_read(4'h1, rd);
      chk(rd, 32'h2);
      chk(marked, MARK_INIT);
      reg_write(4'h0, 32'h0000_0008);
      reg_read(4'h1, rd);
      chk(rd, 32'h4);
      chk(scan_running, 32'h1);
      chk(marked, MARK_INIT);
      pulse_scan();
      chk(marked[2:0], 32'h2);
      // Many short scans: alternation and square-wave rates.
      count_on = 1'b1;
      c_start = cyc;
      for (int i = 0; i < 60; i++) begin
         pulse_scan();
         chk(marked[2:0], {2'b01, ~i[0]});
      end
      count_on = 1'b0;
      el = cyc - c_start;
      chk(n0 >= el / TICK - 2 && n0 <= el / TICK + 2, 32'h1);
      chk(n1 >= el / (5 * TICK) - 1 && n1 <= el / (5 * TICK) + 1, 32'h1);
      // Without a scan end no flag may move.
      saved = marked;
      repeat (40) @(posedge clk);
      #1;
      chk(marked, saved);
      pulse_scan();
      fn_op(1'b1);
      chk(fn_error_flag, 32'h1);
      reg_read(4'h5, rd);
      chk(rd[11], 32'h1);
      fn_op(1'b0);
      chk(fn_error_flag, 32'h0);
      pulse_scan();
      @(posedge clk);
      blk_err <= 1'b1;
      @(posedge clk);
      blk_err <= 1'b0;
      pulse_scan();
      chk(block_error_latch, 32'h1);
      reg_read(4'h0, rd);
      chk(rd[3], 32'h1);
      reg_write(4'h0, 32'h0000_0000);
      chk(block_error_latch, 32'h0);
      reg_write(4'h0, 32'h0000_0004);
      chk(block_error_latch, 32'h1);
      pulse_scan();
      // Hot restart restores the snapshot; cold and warm reinitialise.
      saved = marked;
      restart(2'h2);
      chk(marked, MARK_INIT);
      reg_read(4'h0, rd);
      chk(rd[1:0], 32'h2);
      reg_write(4'h0, 32'h0000_0008);
      chk(marked, saved);
      for (int m = 0; m < 2; m++) begin
         pulse_scan();
         restart(m[1:0]);
         reg_read(4'h0, rd);
         chk(rd[1:0], m);
         reg_write(4'h0, 32'h0000_0008);
         chk(marked, MARK_INIT);
      end
      reg_write(4'h6, 32'h0000_A5C3);
      reg_read(4'h6, rd);
      chk(rd, 32'h0000_A5C3);
      // Each stop-error source lands on its own sticky bit; bit 7 stays clear.
      chk(fatal_system_error_word, 32'h0);
      for (int i = 0; i < 9; i++) begin
         @(posedge clk);
         faults <= 9'h100 >> i;
         @(posedge clk);
         faults <= 9'h000;
         pulse_scan();
         exp_fatal[fb[i]] = 1'b1;
         chk(fatal_system_error_word, exp_fatal);
      end
      reg_read(4'h2, rd);
      chk(rd, exp_fatal);
      restart(2'h0);
      reg_write(4'h0, 32'h0000_0008);
      chk(fatal_system_error_word, 32'h0);
      @(posedge clk);
      fetch_bad <= 1'b1;
      @(posedge clk);
      fetch_bad <= 1'b0;
      pulse_scan();
      chk(fatal_system_error_word, 32'h0200);
      repeat (WDOG + 10) @(posedge clk);
      #1;
      chk(fatal_system_error_word, 32'h0300);
      wrap_up();
   end
endmodule : tb
